// ==== pkg/pwm_dac_pkg.sv ====
// Constants shared by the three-channel PWM converter: register indices, fields,
// reset values and the basic-clock timing counts.
// Assumes a 125 MHz system clock and an AXI4-Lite master with 32-bit data.
package pwm_dac_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CLOCK_SELECT   = 8'h26;
    localparam logic [7:0] IDX_PIN_FUNCTION   = 8'h27;
    localparam logic [7:0] IDX_TIMER_CONTROL  = 8'h28;
    localparam logic [7:0] IDX_STATUS         = 8'h29;
    localparam logic [7:0] IDX_GP_OUTPUT      = 8'h2A;
    localparam logic [7:0] IDX_DUTY_CH0       = 8'h44;
    localparam logic [7:0] IDX_DUTY_CH1       = 8'h45;
    localparam logic [7:0] IDX_DUTY_CH2       = 8'h46;

    // Field positions.
    localparam int BIT_RATE_SELECT   = 0;
    localparam int BIT_WIDTH_SELECT  = 2;
    localparam int BIT_TIMER_CLEAR   = 0;
    localparam int BIT_TIMER_RUN     = 1;
    localparam int BIT_TIMER_SELECT  = 3;
    localparam int STATUS_PIN_LSB    = 12;

    // Reset values.
    localparam logic [3:0] RST_CLOCK_SELECT  = 4'h0;
    localparam logic [3:0] RST_PIN_FUNCTION  = 4'h0;
    localparam logic [3:0] RST_TIMER_CONTROL = 4'h0;
    localparam logic [2:0] RST_GP_OUTPUT     = 3'h7;
    localparam logic [8:0] RST_DUTY          = 9'h1FF;

    // Timing: basic clock rates in Hz and the system-clock counts per pulse.
    localparam int CLK_SYS_HZ      = 125_000_000;
    localparam int BASIC_FAST_HZ   = 1_125_000;
    localparam int BASIC_SLOW_HZ   = 112_500;
    localparam int DIV_FAST        = CLK_SYS_HZ / BASIC_FAST_HZ;
    localparam int DIV_SLOW        = CLK_SYS_HZ / BASIC_SLOW_HZ;
    localparam int QUARTER_FAST    = DIV_FAST / 4;
    localparam int QUARTER_SLOW    = DIV_SLOW / 4;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        WR_IDLE = 4'b0001,
        WR_ADDR = 4'b0010,
        WR_DATA = 4'b0100,
        WR_RESP = 4'b1000
    } wr_state_type;

endpackage

// ==== verilog/pwm_dac.sv ====
// Three-channel PWM digital-to-analogue output block with AXI4-Lite registers.
// Assumes pins are open drain with an external pull-up and lowpass filter, and
// that all inputs are synchronous to clk_sys_i.
//
// Summary of operation
// - Bits 2..0 of pin function register pick PWM or general output per pin.
// - Each pin's mode changes without touching the other pins.
// - Pins only pull low or release; the outside supplies the pull-up.
// - Timer control bit 3 set means timer mode, clear means PWM converter.
// - Timer mode forces all pins to general output, ignoring select flags.
// - 8-bit width: pin high while duty exceeds count, low while smaller.
// - 9-bit width: same comparison, 512-pulse period and 512 duty steps.
// - High time gains an extra quarter basic pulse, so zero still pulses.
// - All channels share basic clock, width and frequency; only duty differs.
// - Basic clock is 1.125 MHz or 0.1125 MHz; 8-bit gives ~4.4 kHz/440 Hz.
// - 9-bit width gives ~2.2 kHz fast and ~220 Hz slow.
// - Duty storage of channel 2 doubles as the timer modulo register.
// - In timer mode duty registers 1 and 0 act as plain 8-bit latches.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

module pwm_dac
    import pwm_dac_pkg::*;
#(
    parameter int NUM_CH = 3
) (
    input  wire logic          clk_sys_i,
    input  wire logic          arst_n_i,
    input  wire logic          soft_clear_i,
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [2:0]    wave_out_pin_i,
    output logic [2:0]         wave_out_pin_o,
    output logic [2:0]         wave_out_pin_oe_n_o
);

    if (NUM_CH != 3) begin : g_bad_channels
        $error("pwm_dac serves exactly three channels");
    end
    if (QUARTER_FAST < 1) begin : g_bad_clock
        $error("system clock too slow for the quarter-pulse offset");
    end

    localparam logic [10:0] DIV_FAST_M1 = 11'(DIV_FAST - 1);
    localparam logic [10:0] DIV_SLOW_M1 = 11'(DIV_SLOW - 1);
    localparam logic [10:0] QTR_FAST    = 11'(QUARTER_FAST);
    localparam logic [10:0] QTR_SLOW    = 11'(QUARTER_SLOW);

    // Word address to register index; flags anything off a word boundary.
    function automatic logic [7:0] word_index(input logic [31:0] addr,
                                              output logic aligned);
        aligned = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h0);
        return addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        return (idx == IDX_CLOCK_SELECT) || (idx == IDX_PIN_FUNCTION) ||
               (idx == IDX_TIMER_CONTROL) || (idx == IDX_STATUS) ||
               (idx == IDX_GP_OUTPUT) || (idx == IDX_DUTY_CH0) ||
               (idx == IDX_DUTY_CH1) || (idx == IDX_DUTY_CH2);
    endfunction

    // Register file state.
    logic [3:0]  clock_select_reg, clock_select_next;
    logic [3:0]  pin_function_reg, pin_function_next;
    logic [3:0]  timer_control_reg, timer_control_next;
    logic [2:0]  gp_output_reg, gp_output_next;
    logic [8:0]  duty_reg [NUM_CH];
    logic [8:0]  duty_next [NUM_CH];
    logic        counter_clear_reg, counter_clear_next;

    // Bus state.
    wr_state_type wr_state_reg, wr_state_next;
    logic [31:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        awready_reg, awready_next;
    logic        wready_reg, wready_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    // Counter state.
    logic [10:0] presc_reg, presc_next;
    logic [8:0]  count_reg, count_next;
    logic [2:0]  level_reg, level_next;
    logic [2:0]  oe_n_reg, oe_n_next;
    logic [2:0]  pin_seen_reg, pin_seen_next;
    logic [2:0]  pin_low_reg;

    logic        timer_mode;
    logic        width9;
    logic [10:0] div_m1;
    logic [10:0] quarter;
    logic        tick;
    logic [2:0]  wave;

    assign timer_mode = timer_control_reg[BIT_TIMER_SELECT];
    assign width9     = clock_select_reg[BIT_WIDTH_SELECT];
    assign div_m1     = clock_select_reg[BIT_RATE_SELECT] ? DIV_SLOW_M1 : DIV_FAST_M1;
    assign quarter    = clock_select_reg[BIT_RATE_SELECT] ? QTR_SLOW : QTR_FAST;
    assign tick       = (presc_reg == div_m1);

    // Write channel: address and data are taken in either order.
    always_comb begin
        logic       waligned;
        logic [7:0] widx;
        logic       do_write;
        waligned        = 1'b0;
        widx            = word_index(waddr_reg, waligned);
        do_write        = 1'b0;
        wr_state_next   = wr_state_reg;
        waddr_next      = waddr_reg;
        wdata_next      = wdata_reg;
        wstrb_next      = wstrb_reg;
        awready_next    = awready_reg;
        wready_next     = wready_reg;
        bvalid_next     = bvalid_reg;
        bresp_next      = bresp_reg;
        case (wr_state_reg)
            WR_IDLE: begin
                awready_next = 1'b1;
                wready_next  = 1'b1;
                if (s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg) begin
                    waddr_next    = s_axi_awaddr;
                    wdata_next    = s_axi_wdata;
                    wstrb_next    = s_axi_wstrb;
                    awready_next  = 1'b0;
                    wready_next   = 1'b0;
                    wr_state_next = WR_RESP;
                end else if (s_axi_awvalid && awready_reg) begin
                    waddr_next    = s_axi_awaddr;
                    awready_next  = 1'b0;
                    wr_state_next = WR_ADDR;
                end else if (s_axi_wvalid && wready_reg) begin
                    wdata_next    = s_axi_wdata;
                    wstrb_next    = s_axi_wstrb;
                    wready_next   = 1'b0;
                    wr_state_next = WR_DATA;
                end
            end
            WR_ADDR: begin
                if (s_axi_wvalid && wready_reg) begin
                    wdata_next    = s_axi_wdata;
                    wstrb_next    = s_axi_wstrb;
                    wready_next   = 1'b0;
                    wr_state_next = WR_RESP;
                end
            end
            WR_DATA: begin
                if (s_axi_awvalid && awready_reg) begin
                    waddr_next    = s_axi_awaddr;
                    awready_next  = 1'b0;
                    wr_state_next = WR_RESP;
                end
            end
            WR_RESP: begin
                if (!bvalid_reg) begin
                    do_write    = 1'b1;
                    bvalid_next = 1'b1;
                    bresp_next  = (waligned && is_mapped(widx)) ? RESP_OKAY : RESP_SLVERR;
                end else if (s_axi_bready) begin
                    bvalid_next   = 1'b0;
                    awready_next  = 1'b1;
                    wready_next   = 1'b1;
                    wr_state_next = WR_IDLE;
                end
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase

        // Register writes land in the cycle the response is raised.
        clock_select_next  = clock_select_reg;
        pin_function_next  = pin_function_reg;
        timer_control_next = timer_control_reg;
        gp_output_next     = gp_output_reg;
        counter_clear_next = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            duty_next[c] = duty_reg[c];
        end
        if (do_write && waligned && wstrb_reg[0]) begin
            case (widx)
                IDX_CLOCK_SELECT: begin
                    clock_select_next = {1'b0, wdata_reg[2], 1'b0, wdata_reg[0]};
                end
                IDX_PIN_FUNCTION: begin
                    pin_function_next = {1'b0, wdata_reg[2:0]};
                end
                IDX_TIMER_CONTROL: begin
                    timer_control_next = {wdata_reg[3], 2'b00, 1'b0} |
                                         (4'(wdata_reg[BIT_TIMER_RUN]) << BIT_TIMER_RUN);
                    counter_clear_next = wdata_reg[BIT_TIMER_CLEAR];
                end
                IDX_GP_OUTPUT: begin
                    gp_output_next = wdata_reg[2:0];
                end
                default: begin
                end
            endcase
        end
        // Each pin has its own duty word; bit 8 rides on the second byte lane.
        for (int c = 0; c < NUM_CH; c++) begin
            if (do_write && waligned && (widx == IDX_DUTY_CH0 + 8'(c))) begin
                if (timer_mode && c < 2) begin
                    if (wstrb_reg[0]) begin
                        duty_next[c] = {1'b0, wdata_reg[7:0]};
                    end
                end else begin
                    if (wstrb_reg[0]) begin
                        duty_next[c][7:0] = wdata_reg[7:0];
                    end
                    if (wstrb_reg[1]) begin
                        duty_next[c][8] = wdata_reg[8];
                    end
                end
            end
        end
        // Watchdog, stack or clock-stop clear; a chip-enable reset leaves these alone.
        if (soft_clear_i) begin
            clock_select_next  = RST_CLOCK_SELECT;
            pin_function_next  = RST_PIN_FUNCTION;
            timer_control_next = RST_TIMER_CONTROL;
            for (int c = 0; c < NUM_CH; c++) begin
                duty_next[c] = RST_DUTY;
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after the address.
    always_comb begin
        logic       raligned;
        logic [7:0] ridx;
        raligned     = 1'b0;
        ridx         = word_index(s_axi_araddr, raligned);
        arready_next = arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_next  = 1'b0;
                arready_next = 1'b1;
            end
        end else if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = (raligned && is_mapped(ridx)) ? RESP_OKAY : RESP_SLVERR;
            rdata_next   = 32'h0000_0000;
            if (raligned) begin
                case (ridx)
                    IDX_CLOCK_SELECT:  rdata_next = 32'(clock_select_reg);
                    IDX_PIN_FUNCTION:  rdata_next = 32'(pin_function_reg);
                    IDX_TIMER_CONTROL: rdata_next = 32'(timer_control_reg);
                    IDX_GP_OUTPUT:     rdata_next = 32'(gp_output_reg);
                    IDX_STATUS:        rdata_next = 32'(count_reg) |
                                                    (32'(pin_seen_reg) << STATUS_PIN_LSB);
                    IDX_DUTY_CH0:      rdata_next = 32'(duty_reg[0]);
                    IDX_DUTY_CH1:      rdata_next = 32'(duty_reg[1]);
                    IDX_DUTY_CH2:      rdata_next = 32'(duty_reg[2]);
                    default:           rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // One shared prescaler and count serve every channel, so all pins share period.
    always_comb begin
        logic [8:0] top;
        top        = width9 ? 9'h1FF : 9'h0FF;
        presc_next = tick ? 11'h000 : presc_reg + 11'h001;
        count_next = count_reg;
        if (timer_mode) begin
            // The timer wraps at the modulo held in channel 2's duty storage.
            if (tick && timer_control_reg[BIT_TIMER_RUN]) begin
                count_next = (count_reg[7:0] == duty_reg[2][7:0]) ? 9'h000 :
                             {1'b0, count_reg[7:0] + 8'h01};
            end
        end else if (tick) begin
            count_next = (count_reg >= top) ? 9'h000 : count_reg + 9'h001;
        end
        if (counter_clear_reg) begin
            count_next = 9'h000;
            presc_next = 11'h000;
        end
        pin_seen_next = wave_out_pin_i;
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_channel
        logic [8:0] eff_duty;
        logic [8:0] eff_count;
        assign eff_duty  = width9 ? duty_reg[c] : {1'b0, duty_reg[c][7:0]};
        assign eff_count = width9 ? count_reg : {1'b0, count_reg[7:0]};
        // Matching value stays high for the first quarter of the pulse.
        assign wave[c] = (eff_duty > eff_count) ||
                         ((eff_duty == eff_count) && (presc_reg < quarter));
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            // Timer mode forces every pin to its general output latch.
            level_next[c] = (!timer_mode && pin_function_reg[c]) ? wave[c]
                                                                 : gp_output_reg[c];
        end
        // Only a low level is driven; a high level releases the line.
        oe_n_next = level_next;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_state_reg      <= WR_IDLE;
            waddr_reg         <= 32'h0000_0000;
            wdata_reg         <= 32'h0000_0000;
            wstrb_reg         <= 4'h0;
            awready_reg       <= 1'b0;
            wready_reg        <= 1'b0;
            bvalid_reg        <= 1'b0;
            bresp_reg         <= RESP_OKAY;
            arready_reg       <= 1'b1;
            rvalid_reg        <= 1'b0;
            rdata_reg         <= 32'h0000_0000;
            rresp_reg         <= RESP_OKAY;
            clock_select_reg  <= RST_CLOCK_SELECT;
            pin_function_reg  <= RST_PIN_FUNCTION;
            timer_control_reg <= RST_TIMER_CONTROL;
            gp_output_reg     <= RST_GP_OUTPUT;
            counter_clear_reg <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                duty_reg[c] <= RST_DUTY;
            end
            presc_reg         <= 11'h000;
            count_reg         <= 9'h000;
            level_reg         <= 3'h7;
            oe_n_reg          <= 3'h7;
            pin_seen_reg      <= 3'h0;
            pin_low_reg       <= 3'h0;
        end else begin
            wr_state_reg      <= wr_state_next;
            waddr_reg         <= waddr_next;
            wdata_reg         <= wdata_next;
            wstrb_reg         <= wstrb_next;
            awready_reg       <= awready_next;
            wready_reg        <= wready_next;
            bvalid_reg        <= bvalid_next;
            bresp_reg         <= bresp_next;
            arready_reg       <= arready_next;
            rvalid_reg        <= rvalid_next;
            rdata_reg         <= rdata_next;
            rresp_reg         <= rresp_next;
            clock_select_reg  <= clock_select_next;
            pin_function_reg  <= pin_function_next;
            timer_control_reg <= timer_control_next;
            gp_output_reg     <= gp_output_next;
            counter_clear_reg <= counter_clear_next;
            for (int c = 0; c < NUM_CH; c++) begin
                duty_reg[c] <= duty_next[c];
            end
            presc_reg         <= presc_next;
            count_reg         <= count_next;
            level_reg         <= level_next;
            oe_n_reg          <= oe_n_next;
            pin_seen_reg      <= pin_seen_next;
            pin_low_reg       <= 3'h0;
        end
    end

    assign s_axi_awready       = awready_reg;
    assign s_axi_wready        = wready_reg;
    assign s_axi_bvalid        = bvalid_reg;
    assign s_axi_bresp         = bresp_reg;
    assign s_axi_arready       = arready_reg;
    assign s_axi_rvalid        = rvalid_reg;
    assign s_axi_rdata         = rdata_reg;
    assign s_axi_rresp         = rresp_reg;
    assign wave_out_pin_o      = pin_low_reg;
    assign wave_out_pin_oe_n_o = oe_n_reg;

endmodule

// ==== testbench/pwm_dac_chk.sv ====
// Checker for the PWM converter: bus handshakes and pin drive.
// Bound to pwm_dac from the bench top; sees only the block's ports.
`timescale 1ns/1ps
module pwm_dac_chk
    import pwm_dac_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [2:0]  wave_out_pin_o,
    input wire logic [2:0]  wave_out_pin_oe_n_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    pin_drive_a: assert property (wave_out_pin_o == 3'h0)
        else $error("pin driven high");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:4] s_axi_bvalid) else $error("write not answered");
    no_accept_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_slverr_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr >= 32'h0000_0400 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    read_close_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read did not close");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property ($rose(wave_out_pin_oe_n_o[0]));
endmodule

// ==== testbench/pin_load.sv ====
// Far side of the three open-drain pins: pull-up resistors and lowpass filter.
// Assumes the converter pulls a pin low only while its enable is low.
`timescale 1ns/1ps
module pin_load (
    input  wire logic [2:0] oe_n_i,
    input  wire logic [2:0] drive_i,
    output logic      [2:0] level_o
);
    // A released pin rises through its pull-up; the filter adds no load worth modelling.
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            level_o[k] = oe_n_i[k] ? 1'b1 : drive_i[k];
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the PWM converter over AXI4-Lite.
// Assumes the default 125 MHz basic-clock divider and the pull-up model.
`timescale 1ns/1ps
module tb_top;
    import pwm_dac_pkg::*;
    logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, soft_clear_i = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [2:0]  pin_level, pin_drive, pin_oe_n;
    int          failures = 0, compares = 0, cycles = 0, high [3];

    pwm_dac pwm_dac_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .soft_clear_i(soft_clear_i), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wave_out_pin_i(pin_level),
        .wave_out_pin_o(pin_drive), .wave_out_pin_oe_n_o(pin_oe_n));
    pin_load pin_load_inst (.oe_n_i(pin_oe_n), .drive_i(pin_drive), .level_o(pin_level));

    always #4 clk_sys_i = ~clk_sys_i;
    // The slowest wait is about half a 9-bit sweep; the ceiling leaves room above it.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 100000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize;
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clk_sys_i);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdreg(input logic [31:0] a);
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clk_sys_i);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        rdreg(ba(idx));
        chk(rd, exp);
    endtask
    // Pins lag the count by a few cycles, so only counts clear of a duty edge are used.
    task automatic status_in(input logic [8:0] lo, input logic [8:0] hi);
        do rdreg(ba(IDX_STATUS)); while (rd[8:0] < lo || rd[8:0] > hi);
    endtask
    task automatic measure;
        high = '{0, 0, 0};
        repeat (256 * DIV_FAST) begin
            @(posedge clk_sys_i);
            for (int k = 0; k < 3; k++) if (pin_level[k]) high[k]++;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rc(IDX_PIN_FUNCTION, 32'h0000_0000);
        rc(IDX_TIMER_CONTROL, 32'h0000_0000);
        rc(IDX_CLOCK_SELECT, 32'h0000_0000);
        rc(IDX_DUTY_CH1, 32'h0000_01FF);
        rdreg(32'h0000_0400);
        chk(resp, RESP_SLVERR);
        wr(32'h0000_0400, 32'h0000_0001);
        chk(resp, RESP_SLVERR);
        wr(ba(IDX_GP_OUTPUT), 32'h0000_0005);
        repeat (3) @(posedge clk_sys_i);
        chk(pin_oe_n, 3'h5);
        wr(ba(IDX_DUTY_CH0), 32'h0000_0000);
        wr(ba(IDX_DUTY_CH1), 32'h0000_01FF);
        wr(ba(IDX_DUTY_CH2), 32'h0000_0080);
        wr(ba(IDX_PIN_FUNCTION), 32'h0000_0007);
        measure();
        chk(high[0], QUARTER_FAST);
        chk(high[1], 255 * DIV_FAST + QUARTER_FAST);
        chk(high[2], 128 * DIV_FAST + QUARTER_FAST);
        wr(ba(IDX_GP_OUTPUT), 32'h0000_0000);
        wr(ba(IDX_PIN_FUNCTION), 32'h0000_0006);
        status_in(9'h002, 9'h07D);
        chk(rd[14:12], 3'h6);
        wr(ba(IDX_TIMER_CONTROL), 32'h0000_000F);
        rc(IDX_TIMER_CONTROL, 32'h0000_000A);
        repeat (3) @(posedge clk_sys_i);
        chk(pin_oe_n, 3'h0);
        wr(ba(IDX_DUTY_CH0), 32'h0000_01AB);
        rc(IDX_DUTY_CH0, 32'h0000_00AB);
        wr(ba(IDX_DUTY_CH2), 32'h0000_00C3);
        rc(IDX_DUTY_CH2, 32'h0000_00C3);
        wr(ba(IDX_TIMER_CONTROL), 32'h0000_0000);
        wr(ba(IDX_CLOCK_SELECT), 32'h0000_0004);
        wr(ba(IDX_DUTY_CH0), 32'h0000_00FF);
        wr(ba(IDX_DUTY_CH2), 32'h0000_0180);
        wr(ba(IDX_PIN_FUNCTION), 32'h0000_0007);
        status_in(9'h102, 9'h17E);
        chk(rd[14:12], 3'h6);
        wr(ba(IDX_CLOCK_SELECT), 32'h0000_0005);
        wr(ba(IDX_TIMER_CONTROL), 32'h0000_0001);
        repeat (1000) @(posedge clk_sys_i);
        rdreg(ba(IDX_STATUS));
        chk(rd[8:0], 9'h000);
        repeat (200) @(posedge clk_sys_i);
        rdreg(ba(IDX_STATUS));
        chk(rd[8:0], 9'h001);
        @(posedge clk_sys_i);
        soft_clear_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_clear_i <= 1'b0;
        rc(IDX_PIN_FUNCTION, 32'h0000_0000);
        rc(IDX_CLOCK_SELECT, 32'h0000_0000);
        summarize();
    end
endmodule

bind pwm_dac pwm_dac_chk pwm_dac_chk_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wave_out_pin_o(wave_out_pin_o),
    .wave_out_pin_oe_n_o(wave_out_pin_oe_n_o));
